// ===== src/gpc_port_ctrl.sv
/*
  General-purpose pin port controller: registers, pin matrix, drive logic, input
  sampling and per-port interrupt requests.
  Assumes a register master of one-cycle strobes and pad cells that take the pad struct.
*/
//
// Overview of operation
// R01: up to 64 pins in ports of at most 8, each pin configured alone.
// R02: eight drive modes per pin, from analog off to weak/strong pull pairs.
// R03: per-pin output data register drives pins; state register shows sampled input.
// R04: enabled pins raise interrupts, combined into one request per port.
// R05: during reset every pin is analog with both buffers off.
// R06: hold freezes each pin's output and configuration during hibernate.
// R07: per-pin input threshold select, CMOS or LVTTL.
// R08: per-pin slow or fast output slew select.
// R09: per-pin matrix picks own data, a peripheral signal or analog.
// R10: pin inputs pass two synchronising flops before state and interrupt use.
module gpc_port_ctrl import gpc_pkg::*; #(
  parameter int NUM_PORTS = GPC_MAX_PORTS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  // pins and peripheral sources
  input wire logic [NUM_PORTS*GPC_PORT_W-1:0] pin_in,
  input wire logic [NUM_PORTS*GPC_PORT_W-1:0] periph_a,
  input wire logic [NUM_PORTS*GPC_PORT_W-1:0] periph_b,
  output gpc_pad_type [NUM_PORTS*GPC_PORT_W-1:0] pad_ff,
  // power and interrupts
  input wire logic hib_hold,
  output logic hold_active_ff,
  output logic [NUM_PORTS-1:0] port_irq_ff
);

  localparam int NP = NUM_PORTS * GPC_PORT_W;

  generate
    if (NUM_PORTS < 1 || NUM_PORTS > GPC_MAX_PORTS) begin : g_bad_ports // R01
      $error("NUM_PORTS must lie between 1 and 8");
    end
  endgenerate

  // drive mode and data to pad controls
  function automatic gpc_pad_type gpc_drive(input gpc_pin_cfg_type cfg, input logic data);
    gpc_pad_type pad;
    pad = GPC_PAD_RESET;
    pad.lvttl = cfg.lvttl;
    pad.slow = cfg.slow;
    pad.ibuf_en = 1'h1;
    pad.analog = 1'h0;
    pad.out = data;
    case (cfg.mode)
      GPC_MODE_ANALOG: begin
        pad.ibuf_en = 1'h0;
        pad.analog = 1'h1;
      end
      GPC_MODE_INPUT: pad.oe_n = 1'h1;
      GPC_MODE_WPU_SPD: begin
        pad.oe_n = data;
        pad.pu_weak = data;
      end
      GPC_MODE_SPU_WPD: begin
        pad.oe_n = !data;
        pad.pd_weak = !data;
      end
      GPC_MODE_OD_LOW: pad.oe_n = data;
      GPC_MODE_OD_HIGH: pad.oe_n = !data;
      GPC_MODE_STRONG: pad.oe_n = 1'h0;
      GPC_MODE_WEAK: begin
        pad.oe_n = 1'h1;
        pad.pu_weak = data;
        pad.pd_weak = !data;
      end
      default: pad = GPC_PAD_RESET;
    endcase
    if (cfg.sel == GPC_SEL_ANALOG) begin
      pad.oe_n = 1'h1;
      pad.ibuf_en = 1'h0;
      pad.pu_weak = 1'h0;
      pad.pd_weak = 1'h0;
      pad.analog = 1'h1;
    end
    return pad;
  endfunction

  logic [NP-1:0] out_ff;
  logic [NP-1:0] state_ff;
  logic [NP-1:0] istat_ff;
  gpc_pin_cfg_type [NP-1:0] cfg_ff;
  logic [NP-1:0] pin_sync;
  logic [NP-1:0] nxt_state;
  logic [NP-1:0] evt;
  logic [31:0] nxt_rdata;
  logic [3:0] rport;
  logic [3:0] ridx;
  logic [NP-1:0] src;
  logic [NP-1:0] ien_vec;
  int rbase;

  assign rport = reg_addr[7:4];
  assign ridx = reg_addr[3:0];
  assign rbase = int'(rport) * GPC_PORT_W;

  gpc_sync #(.WIDTH(NP)) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .din(pin_in),
    .dout(pin_sync)
  );

  // register write hits
  function automatic logic gpc_hit(input logic [3:0] idx, input int pin);
    return reg_wr && ridx == idx && rport == 4'(pin / GPC_PORT_W);
  endfunction

  // output data
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      out_ff <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (gpc_hit(GPC_REG_OUT, i)) begin
          out_ff[i] <= reg_wdata[i % GPC_PORT_W]; // R03
        end
      end
    end
  end

  // per-pin configuration
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_ff <= {NP{GPC_CFG_RESET}};
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (gpc_hit(GPC_REG_MODE, i)) begin
          cfg_ff[i].mode <= reg_wdata[(i % GPC_PORT_W)*GPC_MODE_W +: GPC_MODE_W]; // R02
        end
        if (gpc_hit(GPC_REG_THRESH, i)) begin
          cfg_ff[i].lvttl <= reg_wdata[i % GPC_PORT_W]; // R07
        end
        if (gpc_hit(GPC_REG_SLEW, i)) begin
          cfg_ff[i].slow <= reg_wdata[i % GPC_PORT_W]; // R08
        end
        if (gpc_hit(GPC_REG_IEN, i)) begin
          cfg_ff[i].ien <= reg_wdata[i % GPC_PORT_W]; // R04
        end
        if (gpc_hit(GPC_REG_SEL, i)) begin
          cfg_ff[i].sel <= reg_wdata[(i % GPC_PORT_W)*GPC_SEL_W +: GPC_SEL_W]; // R09
        end
      end
    end
  end

  // pin state and change events
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      ien_vec[i] = cfg_ff[i].ien;
      nxt_state[i] = pin_sync[i] & pad_ff[i].ibuf_en; // R10
      evt[i] = cfg_ff[i].ien && (nxt_state[i] != state_ff[i]); // R04
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state; // R03
    end
  end

  // sticky interrupt status, write one to clear, a new event wins
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      istat_ff <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (evt[i]) begin
          istat_ff[i] <= 1'h1; // R04
        end else if (gpc_hit(GPC_REG_ISTAT, i) && reg_wdata[i % GPC_PORT_W]) begin
          istat_ff[i] <= 1'h0;
        end
      end
    end
  end

  // one request per port
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      port_irq_ff <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        port_irq_ff[p] <= |(istat_ff[p*GPC_PORT_W +: GPC_PORT_W]
          & ien_vec[p*GPC_PORT_W +: GPC_PORT_W]); // R04
      end
    end
  end

  sequence pin0_event_s;
    evt[0] && cfg_ff[0].ien;
  endsequence

  evt_sticky_a: assert property (@(posedge mclk) disable iff (!resetn) // R04
    pin0_event_s |=> istat_ff[0])
    else $error("pin event did not set its status");

  irq_combine_a: assert property (@(posedge mclk) disable iff (!resetn) // R04
    (istat_ff[0] && cfg_ff[0].ien) |=> port_irq_ff[0])
    else $error("enabled pin status did not raise the port request");

  // pin matrix source
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      case (cfg_ff[i].sel)
        GPC_SEL_PERIPH_A: src[i] = periph_a[i]; // R09
        GPC_SEL_PERIPH_B: src[i] = periph_b[i]; // R09
        default: src[i] = out_ff[i]; // R03
      endcase
    end
  end

  // hold follows the hibernate request
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hold_active_ff <= 1'h0;
    end else begin
      hold_active_ff <= hib_hold; // R06
    end
  end

  // pad controls, frozen while held
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pad_ff <= {NP{GPC_PAD_RESET}}; // R05
    end else if (!hold_active_ff) begin // R06
      for (int i = 0; i < NP; i++) begin
        pad_ff[i] <= gpc_drive(cfg_ff[i], src[i]); // R02 R07 R08
      end
    end
  end

  reset_pads_a: assert property (@(posedge mclk) !resetn |=> pad_ff == {NP{GPC_PAD_RESET}}) // R05
    else $error("pads not in analog mode during reset");

  hold_freeze_a: assert property (@(posedge mclk) disable iff (!resetn) // R06
    hold_active_ff |=> $stable(pad_ff))
    else $error("pad controls moved while held");

  hold_follow_a: assert property (@(posedge mclk) disable iff (!resetn) // R06
    1'b1 |=> hold_active_ff == $past(hib_hold))
    else $error("hold flag does not follow the hibernate request");

  // register read mux
  always_comb begin
    nxt_rdata = '0;
    if (int'(rport) < NUM_PORTS) begin
      for (int j = 0; j < GPC_PORT_W; j++) begin
        case (ridx)
          GPC_REG_OUT: nxt_rdata[j] = out_ff[rbase + j];
          GPC_REG_STATE: nxt_rdata[j] = state_ff[rbase + j]; // R03
          GPC_REG_MODE: nxt_rdata[j*GPC_MODE_W +: GPC_MODE_W] = cfg_ff[rbase + j].mode;
          GPC_REG_THRESH: nxt_rdata[j] = cfg_ff[rbase + j].lvttl;
          GPC_REG_SLEW: nxt_rdata[j] = cfg_ff[rbase + j].slow;
          GPC_REG_IEN: nxt_rdata[j] = cfg_ff[rbase + j].ien;
          GPC_REG_ISTAT: nxt_rdata[j] = istat_ff[rbase + j];
          GPC_REG_SEL: nxt_rdata[j*GPC_SEL_W +: GPC_SEL_W] = cfg_ff[rbase + j].sel;
          GPC_REG_HOLD: nxt_rdata[0] = hold_active_ff;
          default: nxt_rdata[j] = 1'h0;
        endcase
      end
    end
  end

  // read data stand one cycle only
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reg_rdata_ff <= '0;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= '0;
    end
  end

  read_idle_a: assert property (@(posedge mclk) disable iff (!resetn) // R03
    !reg_rd |=> reg_rdata_ff == 32'h0)
    else $error("read data present without a read");

endmodule

// ===== common/gpc_pkg.sv
/*
  Shared constants and carrier types of the general-purpose pin port controller.
  Assumes 32-bit register data and an 8-bit register address split as port and index.
*/
package gpc_pkg;

  // port geometry
  localparam int GPC_MAX_PORTS = 8;
  localparam int GPC_PORT_W = 8;

  // register index within a port, address[3:0]; port number is address[7:4]
  localparam logic [3:0] GPC_REG_OUT = 4'h0;
  localparam logic [3:0] GPC_REG_STATE = 4'h1;
  localparam logic [3:0] GPC_REG_MODE = 4'h2;
  localparam logic [3:0] GPC_REG_THRESH = 4'h3;
  localparam logic [3:0] GPC_REG_SLEW = 4'h4;
  localparam logic [3:0] GPC_REG_IEN = 4'h5;
  localparam logic [3:0] GPC_REG_ISTAT = 4'h6;
  localparam logic [3:0] GPC_REG_SEL = 4'h7;
  localparam logic [3:0] GPC_REG_HOLD = 4'h8;

  // field widths inside the packed per-port registers
  localparam int GPC_MODE_W = 3;
  localparam int GPC_SEL_W = 2;

  // drive modes
  localparam logic [2:0] GPC_MODE_ANALOG = 3'h0;
  localparam logic [2:0] GPC_MODE_INPUT = 3'h1;
  localparam logic [2:0] GPC_MODE_WPU_SPD = 3'h2;
  localparam logic [2:0] GPC_MODE_SPU_WPD = 3'h3;
  localparam logic [2:0] GPC_MODE_OD_LOW = 3'h4;
  localparam logic [2:0] GPC_MODE_OD_HIGH = 3'h5;
  localparam logic [2:0] GPC_MODE_STRONG = 3'h6;
  localparam logic [2:0] GPC_MODE_WEAK = 3'h7;

  // pin matrix sources
  localparam logic [1:0] GPC_SEL_GPIO = 2'h0;
  localparam logic [1:0] GPC_SEL_PERIPH_A = 2'h1;
  localparam logic [1:0] GPC_SEL_PERIPH_B = 2'h2;
  localparam logic [1:0] GPC_SEL_ANALOG = 2'h3;

  typedef struct packed {
    logic [2:0] mode;
    logic lvttl;
    logic slow;
    logic ien;
    logic [1:0] sel;
  } gpc_pin_cfg_type;

  typedef struct packed {
    logic oe_n;
    logic out;
    logic ibuf_en;
    logic pu_weak;
    logic pd_weak;
    logic analog;
    logic lvttl;
    logic slow;
  } gpc_pad_type;

  localparam gpc_pin_cfg_type GPC_CFG_RESET = '{mode: GPC_MODE_ANALOG, lvttl: 1'h0,
    slow: 1'h0, ien: 1'h0, sel: GPC_SEL_GPIO};
  localparam gpc_pad_type GPC_PAD_RESET = '{oe_n: 1'h1, out: 1'h0, ibuf_en: 1'h0,
    pu_weak: 1'h0, pd_weak: 1'h0, analog: 1'h1, lvttl: 1'h0, slow: 1'h0};

endpackage

// ===== src/gpc_sync.sv
/*
  Two-stage input synchroniser for the pin inputs.
  Assumes one clock and a synchronous active-low reset.
*/
module gpc_sync #(
  parameter int WIDTH = 64
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_ff <= '0;
      dout <= '0;
    end else begin
      meta_ff <= din; // R10
      dout <= meta_ff; // R10
    end
  end

  sync_delay_a: assert property (@(posedge mclk) disable iff (!resetn) // R10
    resetn [*3] |-> dout == $past(din, 2))
    else $error("synchroniser output is not the input two cycles late");

endmodule

// ===== sim/gpc_pins.sv
/*
  Pin model: resolves each pad's drive and pulls against outside levels.
  Assumes one pad struct for each pin from the controller.
*/
module gpc_pins import gpc_pkg::*; #(
  parameter int N = 16
) (
  // pads and outside drive
  input wire gpc_pad_type [N-1:0] pad,
  input wire logic [N-1:0] ext,
  // resolved pin levels
  output logic [N-1:0] level
);
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (!pad[i].oe_n) level[i] = pad[i].out;
      else if (pad[i].pu_weak) level[i] = 1'h1;
      else if (pad[i].pd_weak) level[i] = 1'h0;
      else level[i] = ext[i];
    end
  end
endmodule

// ===== sim/tb.sv
/*
  Bench for the pin port controller: register tasks, pad and interrupt checks.
  Assumes the pin model gpc_pins and two ports of eight pins.
*/
module tb import gpc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic hib_hold = 1'h0;
  logic [31:0] reg_rdata_ff, rv;
  logic [15:0] pin_in;
  logic [15:0] ext = 16'h0;
  logic [15:0] pa = 16'h0;
  logic [15:0] pb = 16'h0;
  logic hold_active_ff;
  logic [1:0] port_irq_ff;
  gpc_pad_type [15:0] pad_ff;
  int fail_count = 0;
  int checked = 0;

  gpc_port_ctrl #(.NUM_PORTS(2)) dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .pin_in(pin_in), .periph_a(pa), .periph_b(pb), .pad_ff(pad_ff), .hib_hold(hib_hold),
    .hold_active_ff(hold_active_ff), .port_irq_ff(port_irq_ff));
  gpc_pins #(.N(16)) pins (.pad(pad_ff), .ext(ext), .level(pin_in));

  always #5 mclk = ~mclk;

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 rv = reg_rdata_ff;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  function automatic logic [15:0] fld(input int k);
    for (int i = 0; i < 16; i++) fld[i] = pad_ff[i][k];
  endfunction
  task padrst();
    for (int i = 0; i < 16; i++) cmp(32'(pad_ff[i]), 32'(GPC_PAD_RESET));
  endtask
  task finish_test();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100us;
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'h1;
    #1 padrst();
    settle();
    padrst();
    $display("reset test done");
    wr(8'h00, 32'hA5);
    rd(8'h00);
    cmp(rv, 32'hA5);
    wr(8'h02, 32'hDB6DB6);
    settle();
    cmp(fld(7), 16'hFF00);
    cmp(fld(6), 16'h00A5);
    wr(8'h02, 32'h924924);
    settle();
    cmp(fld(7), 16'hFFA5);
    $display("drive test done");
    wr(8'h12, 32'h249249);
    ext <= 16'h3C00;
    settle();
    rd(8'h11);
    cmp(rv, 32'h3C);
    wr(8'h03, 32'hF0);
    wr(8'h04, 32'h0F);
    settle();
    cmp(fld(1), 16'h00F0);
    cmp(fld(0), 16'h000F);
    wr(8'h02, 32'hFFFFFF);
    settle();
    rd(8'h02);
    cmp(rv, 32'hFFFFFF);
    cmp(fld(4), 16'h00A5);
    cmp(fld(3), 16'h005A);
    cmp(fld(5), 16'hFFFF);
    $display("input test done");
    wr(8'h02, 32'hDB6DB6);
    wr(8'h07, 32'h5555);
    pa <= 16'h0033;
    settle();
    cmp(fld(6), 16'h0033);
    wr(8'h07, 32'hFFFF);
    settle();
    cmp(fld(2), 16'h00FF);
    wr(8'h07, 32'hAAAA);
    pb <= 16'h0081;
    settle();
    cmp(fld(6), 16'h0081);
    wr(8'h07, 32'h5555);
    rd(8'h07);
    cmp(rv, 32'h5555);
    $display("matrix test done");
    cmp(32'(port_irq_ff), 32'h0);
    wr(8'h15, 32'h01);
    ext <= 16'h3D00;
    for (int n = 0; n < 8 && port_irq_ff !== 2'h2; n++) @(posedge mclk);
    #1 cmp(32'(port_irq_ff), 32'h2);
    rd(8'h16);
    cmp(rv, 32'h1);
    wr(8'h16, 32'h01);
    settle();
    cmp(32'(port_irq_ff), 32'h0);
    $display("interrupt test done");
    @(posedge mclk);
    hib_hold <= 1'h1;
    settle();
    cmp(32'(hold_active_ff), 32'h1);
    rd(8'h08);
    cmp(rv, 32'h1);
    @(posedge mclk);
    pa <= 16'h00CC;
    wr(8'h03, 32'h00);
    settle();
    cmp(fld(6), 16'h0033);
    cmp(fld(1), 16'h00F0);
    @(posedge mclk);
    hib_hold <= 1'h0;
    settle();
    cmp(fld(6), 16'h00CC);
    $display("hold test done");
    @(posedge mclk);
    resetn <= 1'h0;
    settle();
    padrst();
    cmp(32'(port_irq_ff), 32'h0);
    $display("second reset test done");
    finish_test();
  end
endmodule
